// ==== common/srs_pkg.sv ====
package srs_pkg;

	// ==========================================================
	// register offsets (byte addresses on the bus)
	localparam logic [7:0] OFS_WAKE_EVENT_MASK   = 8'h08;
	localparam logic [7:0] OFS_CHIP_VERSION      = 8'h64;
	localparam logic [7:0] OFS_PORT_B            = 8'h61;
	localparam logic [7:0] OFS_WAKE_ACT_MASK     = 8'h75;
	localparam logic [7:0] OFS_PM_INT_ENABLE     = 8'h82;
	localparam logic [7:0] OFS_SLEEP_SUSP_TMO    = 8'h86;
	localparam logic [7:0] OFS_SOCKET_A_STATE    = 8'ha2;
	localparam logic [7:0] OFS_PM_INT_CAUSE      = 8'ha5;
	localparam logic [7:0] OFS_SOCKET_B_WINSEL   = 8'ha9;
	localparam logic [7:0] OFS_SMM_WINDOW_PAGE   = 8'haa;
	localparam logic [7:0] OFS_SMM_CTRL          = 8'hc0;
	localparam logic [7:0] OFS_PM_STATUS         = 8'hc4;

	// ==========================================================
	// field positions
	localparam int BIT_CAUSE_RESUME  = 0;
	localparam int BIT_CAUSE_S2S     = 3;
	localparam int BIT_EN_RESUME     = 0;
	localparam int BIT_EN_S2S        = 3;
	localparam int BIT_SEL_SMI       = 7;
	localparam int BIT_VER_IN_SMM    = 7;
	localparam int BIT_PORTB_REFRESH = 4;
	localparam int BIT_SMM_ACTIVE    = 0;
	localparam int BIT_SMM_RETURN    = 1;
	localparam logic [7:0] ACT_MASK_WAKE_BITS = 8'h5f;

	// ==========================================================
	// reset values
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_TMO  = 8'h00;

	// ==========================================================
	// timing: refresh at 8192 per second derived from 100 MHz
	localparam int CLK_HZ        = 100_000_000;
	localparam int REFRESH_HZ    = 8192;
	localparam int REFRESH_CYC   = CLK_HZ / REFRESH_HZ;
	// timeout unit: one timer count per this many refreshes
	localparam int TMO_UNIT_REFR = 8;

	typedef enum logic [2:0] {
		PM_HIGH,
		PM_LOW,
		PM_DOZE,
		PM_SLEEP,
		PM_SUSPEND,
		PM_OFF
	} srs_mode_e;

	typedef struct packed {
		logic [7:0] address;
		logic       read;
		logic       write;
		logic [31:0] writedata;
	} srs_req_s;

endpackage

// ==== rtl/srs_sequencer.sv ====
`timescale 1ns/100ps
module srs_sequencer
#(parameter int REFR_CYC = srs_pkg::REFRESH_CYC)
(
	input  wire logic              i_ref_clk,
	input  wire logic              i_rst_b,
	input  wire logic [7:0]        i_avs_address,
	input  wire logic              i_avs_read,
	input  wire logic              i_avs_write,
	input  wire logic [31:0]       i_avs_writedata,
	output logic [31:0]            o_avs_readdata,
	output logic                   o_avs_waitrequest,
	input  wire logic              i_suspend_resume_key_input,
	input  wire logic [7:0]        i_wake_events,
	input  wire logic [7:0]        i_wake_activity,
	output logic                   o_smi_req,
	output logic                   o_nmi_req,
	output logic [2:0]             o_pm_mode,
	output logic                   o_temp_on,
	output logic                   o_cpu_clk_run,
	output logic                   o_refresh_tick,
	output logic [1:0]             o_smm_window_sel,
	output logic [7:0]             o_smm_window_page
);

	// ==========================================================
	// pin synchroniser and edge detect
	logic key_meta_r;
	logic key_sync_r;
	logic key_prev_r;
	logic key_rise;
	logic [7:0] wake_evt_meta_r, wake_evt_sync_r;
	logic [7:0] wake_act_meta_r, wake_act_sync_r;

	always_ff @(posedge i_ref_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			key_meta_r <= 1'b0;
			key_sync_r <= 1'b0;
			key_prev_r <= 1'b0;
			wake_evt_meta_r <= 8'h00;
			wake_evt_sync_r <= 8'h00;
			wake_act_meta_r <= 8'h00;
			wake_act_sync_r <= 8'h00;
		end
		else
		begin
			key_meta_r <= i_suspend_resume_key_input;
			key_sync_r <= key_meta_r;
			key_prev_r <= key_sync_r;
			wake_evt_meta_r <= i_wake_events;
			wake_evt_sync_r <= wake_evt_meta_r;
			wake_act_meta_r <= i_wake_activity;
			wake_act_sync_r <= wake_act_meta_r;
		end
	end

	assign key_rise = key_sync_r & ~key_prev_r;

	// ==========================================================
	// refresh tick generator
	localparam logic [15:0] REFR_LAST = 16'(REFR_CYC - 1);
	logic [15:0] refr_cnt_r;
	logic        refr_tick;
	logic        refr_toggle_r;

	assign refr_tick = (refr_cnt_r == REFR_LAST);

	always_ff @(posedge i_ref_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			refr_cnt_r <= 16'h0000;
		else if (refr_tick)
			refr_cnt_r <= 16'h0000;
		else
			refr_cnt_r <= refr_cnt_r + 16'h0001;
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			refr_toggle_r <= 1'b0;
		else if (refr_tick)
			refr_toggle_r <= ~refr_toggle_r;
	end

	// ==========================================================
	// bus decode; writes answer at once, reads wait one cycle
	logic wr_en;
	logic rd_ack_r;
	logic rd_en;
	logic wr_cause;
	logic wr_socket_a;

	assign o_avs_waitrequest = rd_en && !rd_ack_r;
	assign wr_en       = i_avs_write;
	assign rd_en       = i_avs_read;
	assign wr_cause    = wr_en
		&& (i_avs_address == srs_pkg::OFS_PM_INT_CAUSE);
	assign wr_socket_a = wr_en
		&& (i_avs_address == srs_pkg::OFS_SOCKET_A_STATE);

	logic [7:0] wake_evt_mask_r;
	logic [7:0] wake_act_mask_r;
	logic [7:0] int_enable_r;
	logic [7:0] tmo_r;
	logic [7:0] socket_a_r;
	logic [7:0] winsel_r;
	logic [7:0] page_r;

	always_ff @(posedge i_ref_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			wake_evt_mask_r <= srs_pkg::RST_ZERO;
			wake_act_mask_r <= srs_pkg::RST_ZERO;
			int_enable_r    <= srs_pkg::RST_ZERO;
			tmo_r           <= srs_pkg::RST_TMO;
			socket_a_r      <= srs_pkg::RST_ZERO;
			winsel_r        <= srs_pkg::RST_ZERO;
			page_r          <= srs_pkg::RST_ZERO;
		end
		else if (wr_en)
		begin
			unique case (i_avs_address)
				srs_pkg::OFS_WAKE_EVENT_MASK:
					wake_evt_mask_r <= i_avs_writedata[7:0];
				srs_pkg::OFS_WAKE_ACT_MASK:
					wake_act_mask_r <= i_avs_writedata[7:0];
				srs_pkg::OFS_PM_INT_ENABLE:
					int_enable_r <= i_avs_writedata[7:0];
				srs_pkg::OFS_SLEEP_SUSP_TMO:
					tmo_r <= i_avs_writedata[7:0];
				srs_pkg::OFS_SOCKET_A_STATE:
					socket_a_r <= i_avs_writedata[7:0];
				srs_pkg::OFS_SOCKET_B_WINSEL:
					winsel_r <= i_avs_writedata[7:0];
				srs_pkg::OFS_SMM_WINDOW_PAGE:
					page_r <= i_avs_writedata[7:0];
				default:
					;
			endcase
		end
	end

	// ==========================================================
	// smm tracking: cpu side reports entry and return here
	logic in_smm_r;
	logic smm_entry;
	logic smm_return;

	assign smm_entry  = wr_en && (i_avs_address == srs_pkg::OFS_SMM_CTRL)
		&& i_avs_writedata[srs_pkg::BIT_SMM_ACTIVE];
	assign smm_return = wr_en && (i_avs_address == srs_pkg::OFS_SMM_CTRL)
		&& i_avs_writedata[srs_pkg::BIT_SMM_RETURN];

	always_ff @(posedge i_ref_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			in_smm_r <= 1'b0;
		else if (smm_entry)
			in_smm_r <= 1'b1;
		else if (smm_return)
			in_smm_r <= 1'b0;
	end

	// ==========================================================
	// power mode sequencer
	srs_pkg::srs_mode_e mode_r;
	logic               stepping_r;
	logic               temp_on_r;
	logic               held_evt_r;
	logic               leave_temp_r;
	logic               resume_pend_r;
	logic [10:0]        s2s_cnt_r;
	logic               run_mode;
	logic               sleepish;
	logic               wake_other;
	logic               s2s_expire;
	logic               evt_now;

	assign run_mode = (mode_r == srs_pkg::PM_HIGH)
		|| (mode_r == srs_pkg::PM_LOW)
		|| (mode_r == srs_pkg::PM_DOZE);
	assign sleepish = !run_mode;
	// other wake sources pass only where unmasked
	assign wake_other = |(wake_evt_sync_r & ~wake_evt_mask_r)
		|| |(wake_act_sync_r & srs_pkg::ACT_MASK_WAKE_BITS
		& ~wake_act_mask_r);
	// held event replays when the cause register is written
	assign evt_now = (key_rise && (!temp_on_r || leave_temp_r || wr_cause))
		|| (wr_cause && held_evt_r);
	// a timeout of zero never expires, so the suspend smi never comes
	assign s2s_expire = refr_tick && (mode_r == srs_pkg::PM_SLEEP)
		&& !temp_on_r && !leave_temp_r && (tmo_r != 8'h00)
		&& (s2s_cnt_r == 11'({tmo_r, 3'b000}) - 11'h001);

	always_ff @(posedge i_ref_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			s2s_cnt_r <= 11'h000;
		else if (mode_r != srs_pkg::PM_SLEEP || temp_on_r)
			s2s_cnt_r <= 11'h000;
		else if (refr_tick)
			s2s_cnt_r <= s2s_cnt_r + 11'h001;
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			held_evt_r <= 1'b0;
		else if (temp_on_r && !leave_temp_r && !wr_cause && key_rise)
			held_evt_r <= 1'b1;
		else if (wr_cause)
			held_evt_r <= 1'b0;
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			leave_temp_r <= 1'b0;
		else if (temp_on_r && wr_cause)
			leave_temp_r <= 1'b1;
		else if (refr_tick)
			leave_temp_r <= 1'b0;
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			temp_on_r <= 1'b0;
		else if (s2s_expire)
			temp_on_r <= 1'b1;
		else if (leave_temp_r && refr_tick)
			temp_on_r <= 1'b0;
	end

	// step-down lock: further pin activity ignored until sleep
	always_ff @(posedge i_ref_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			stepping_r <= 1'b0;
		else if (evt_now && run_mode && !stepping_r)
			stepping_r <= 1'b1;
		else if (refr_tick && mode_r == srs_pkg::PM_DOZE)
			stepping_r <= 1'b0;
	end

	// resume latched until the next refresh
	always_ff @(posedge i_ref_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			resume_pend_r <= 1'b0;
		else if ((evt_now || wake_other) && sleepish)
			resume_pend_r <= 1'b1;
		else if (refr_tick)
			resume_pend_r <= 1'b0;
	end

	logic resume_fire;
	assign resume_fire = refr_tick && resume_pend_r
		&& (!temp_on_r || leave_temp_r);

	always_ff @(posedge i_ref_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			mode_r <= srs_pkg::PM_HIGH;
		else if (refr_tick)
		begin
			if (resume_fire)
				mode_r <= srs_pkg::PM_HIGH;
			else if (leave_temp_r)
				mode_r <= srs_pkg::PM_SUSPEND;
			else if (stepping_r)
			begin
				unique case (mode_r)
					srs_pkg::PM_HIGH: mode_r <= srs_pkg::PM_LOW;
					srs_pkg::PM_LOW:  mode_r <= srs_pkg::PM_DOZE;
					srs_pkg::PM_DOZE: mode_r <= srs_pkg::PM_SLEEP;
					default:          mode_r <= mode_r;
				endcase
			end
		end
	end

	// ==========================================================
	// cause flags and smi request; set wins over clear
	logic [7:0] cause_r;
	logic       req_r;
	logic       set_resume;
	logic       set_s2s;

	assign set_resume = resume_fire && resume_pend_r
		&& int_enable_r[srs_pkg::BIT_EN_RESUME];
	assign set_s2s    = s2s_expire;

	always_ff @(posedge i_ref_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			cause_r <= srs_pkg::RST_ZERO;
		else
		begin
			cause_r[srs_pkg::BIT_CAUSE_RESUME] <= set_resume
				|| (cause_r[srs_pkg::BIT_CAUSE_RESUME] && !wr_cause);
			cause_r[srs_pkg::BIT_CAUSE_S2S] <= set_s2s
				|| (cause_r[srs_pkg::BIT_CAUSE_S2S] && !wr_cause);
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			req_r <= 1'b0;
		else if (set_resume || set_s2s)
			req_r <= 1'b1;
		else if (wr_socket_a)
			req_r <= 1'b0;
	end

	assign o_smi_req = req_r && winsel_r[srs_pkg::BIT_SEL_SMI];
	assign o_nmi_req = req_r && !winsel_r[srs_pkg::BIT_SEL_SMI];

	// ==========================================================
	// read data, registered
	logic [7:0] rd_mux;

	always_comb
	begin
		rd_mux = 8'h00;
		unique case (i_avs_address)
			srs_pkg::OFS_WAKE_EVENT_MASK: rd_mux = wake_evt_mask_r;
			srs_pkg::OFS_WAKE_ACT_MASK:   rd_mux = wake_act_mask_r;
			srs_pkg::OFS_PM_INT_ENABLE:   rd_mux = int_enable_r;
			srs_pkg::OFS_SLEEP_SUSP_TMO:  rd_mux = tmo_r;
			srs_pkg::OFS_SOCKET_A_STATE:  rd_mux = socket_a_r;
			srs_pkg::OFS_PM_INT_CAUSE:    rd_mux = cause_r;
			srs_pkg::OFS_SOCKET_B_WINSEL: rd_mux = winsel_r;
			srs_pkg::OFS_SMM_WINDOW_PAGE: rd_mux = page_r;
			srs_pkg::OFS_CHIP_VERSION:
				rd_mux = {in_smm_r, 7'h00};
			srs_pkg::OFS_PORT_B:
				rd_mux = {3'h0, refr_toggle_r, 4'h0};
			srs_pkg::OFS_PM_STATUS:
				rd_mux = {3'h0, temp_on_r, stepping_r, 3'(mode_r)};
			default:                      rd_mux = 8'h00;
		endcase
	end

	// one wait state buys a registered read path
	logic [31:0] readdata_r;
	always_ff @(posedge i_ref_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			rd_ack_r   <= 1'b0;
			readdata_r <= 32'h00000000;
		end
		else
		begin
			rd_ack_r <= rd_en && !rd_ack_r;
			if (rd_en && !rd_ack_r)
				readdata_r <= {24'h000000, rd_mux};
		end
	end

	assign o_avs_readdata = readdata_r;

	assign o_pm_mode         = 3'(mode_r);
	assign o_temp_on         = temp_on_r;
	assign o_cpu_clk_run     = run_mode || temp_on_r;
	assign o_refresh_tick    = refr_tick;
	assign o_smm_window_sel  = winsel_r[5:4];
	assign o_smm_window_page = page_r;

endmodule // srs_sequencer

// ==== verif/srs_cpu_model.sv ====
`timescale 1ns/100ps
// ==========================================================
// cpu core seen from the sequencer: level smi, masked in smm
module srs_cpu_model
(
	input  wire logic       i_ref_clk,
	input  wire logic       i_rst_b,
	input  wire logic       i_smi_req,
	input  wire logic       i_smm_return,
	output logic            o_in_smm,
	output logic [3:0]      o_smi_taken
);
	// a request still held at return is taken at once
	always_ff @(posedge i_ref_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			o_in_smm    <= 1'b0;
			o_smi_taken <= 4'h0;
		end
		else if (i_smi_req && (!o_in_smm || i_smm_return))
		begin
			o_in_smm    <= 1'b1;
			o_smi_taken <= o_smi_taken + 4'h1;
		end
		else if (i_smm_return)
			o_in_smm <= 1'b0;
	end
endmodule // srs_cpu_model

// ==== verif/srs_sequencer_sva.sv ====
`timescale 1ns/100ps
module srs_sequencer_sva
(
	input wire logic        i_ref_clk,
	input wire logic        i_rst_b,
	input wire logic [7:0]  i_avs_address,
	input wire logic        i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic        o_avs_waitrequest,
	input wire logic        o_smi_req,
	input wire logic        o_nmi_req,
	input wire logic [2:0]  o_pm_mode,
	input wire logic        o_temp_on,
	input wire logic        o_cpu_clk_run,
	input wire logic        o_refresh_tick,
	input wire logic [1:0]  o_smm_window_sel,
	input wire logic [7:0]  o_smm_window_page
);
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_b);
	// ==========================================================
	// properties
	AST_WAIT_LOW: assert property (i_avs_write |-> !o_avs_waitrequest)
		else $error("write made to wait");
	AST_WAIT_ONE: assert property (o_avs_waitrequest |=> !o_avs_waitrequest)
		else $error("read waited too long");
	AST_MODE_ON_TICK: assert property ($changed(o_pm_mode)
		|-> $past(o_refresh_tick))
		else $error("mode changed off tick");
	AST_STEP_ONE: assert property ($changed(o_pm_mode)
		&& $past(o_pm_mode) < 3'h3
		|-> o_pm_mode == $past(o_pm_mode) + 3'h1)
		else $error("step down skipped a mode");
	AST_RESUME_HIGH: assert property ($changed(o_pm_mode)
		&& $past(o_pm_mode) >= 3'h3 && !$past(o_temp_on)
		|-> o_pm_mode == 3'h0)
		else $error("wake not to high speed");
	AST_SMI_CLEAR: assert property (i_avs_write
		&& i_avs_address == srs_pkg::OFS_SOCKET_A_STATE
		&& !o_refresh_tick |=> !o_smi_req && !o_nmi_req)
		else $error("request not removed");
	AST_ONE_KIND: assert property (!(o_smi_req && o_nmi_req))
		else $error("smi and nmi together");
	AST_WIN_SEL: assert property (i_avs_write
		&& i_avs_address == srs_pkg::OFS_SOCKET_B_WINSEL
		|=> o_smm_window_sel == $past(i_avs_writedata[5:4]))
		else $error("window select wrong");
	AST_WIN_PAGE: assert property (i_avs_write
		&& i_avs_address == srs_pkg::OFS_SMM_WINDOW_PAGE
		|=> o_smm_window_page == $past(i_avs_writedata[7:0]))
		else $error("window page wrong");
	AST_CLK_RUN: assert property (o_cpu_clk_run
		== (o_pm_mode < 3'h3 || o_temp_on))
		else $error("cpu clock state wrong");
	AST_TICK_PULSE: assert property (o_refresh_tick
		|=> !o_refresh_tick [*8])
		else $error("tick too long");
	cover property ($rose(o_temp_on));
	cover property ($rose(o_smi_req));
	cover property (o_pm_mode == 3'h4);
endmodule // srs_sequencer_sva

bind srs_sequencer srs_sequencer_sva u_sva (.i_ref_clk, .i_rst_b,
	.i_avs_address, .i_avs_write, .i_avs_writedata, .o_avs_waitrequest,
	.o_smi_req, .o_nmi_req, .o_pm_mode, .o_temp_on, .o_cpu_clk_run,
	.o_refresh_tick, .o_smm_window_sel, .o_smm_window_page);

// ==== verif/srs_sequencer_tb_top.sv ====
`timescale 1ns/100ps
module srs_sequencer_tb_top;
	logic clk = 0, rst_b = 0, rd = 0, wr = 0, key = 0, ret = 0;
	logic [7:0] adr = 8'h00, wev = 8'h00, wact = 8'h00;
	logic [31:0] wd = 32'h0, rdat, d;
	logic waitreq, smi, nmi, temp_on, clk_run, tick, in_smm;
	logic [2:0] mode;
	logic [3:0] taken;
	logic [7:0] page;
	logic [1:0] wsel;
	int n_mismatch = 0, cmp_count = 0;
	always #5 clk = ~clk;
	// short refresh period keeps the run brief
	srs_sequencer #(.REFR_CYC(128)) dut (.i_ref_clk(clk), .i_rst_b(rst_b),
		.i_avs_address(adr),
		.i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
		.o_avs_readdata(rdat), .o_avs_waitrequest(waitreq),
		.i_suspend_resume_key_input(key), .i_wake_events(wev),
		.i_wake_activity(wact), .o_smi_req(smi), .o_nmi_req(nmi),
		.o_pm_mode(mode), .o_temp_on(temp_on), .o_cpu_clk_run(clk_run),
		.o_refresh_tick(tick), .o_smm_window_sel(wsel),
		.o_smm_window_page(page));
	srs_cpu_model u_cpu (.i_ref_clk(clk), .i_rst_b(rst_b), .i_smi_req(smi),
		.i_smm_return(ret), .o_in_smm(in_smm), .o_smi_taken(taken));
	// ==========================================================
	// report
	task automatic complete_run();
		$display("checks %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	// ==========================================================
	// bus access, held until waitrequest is seen low
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] v);
		int n;
		@(posedge clk);
		adr <= a;
		wd <= {24'h0, v};
		if (w) wr <= 1'b1; else rd <= 1'b1;
		n = 0;
		do begin @(posedge clk); n++; end
		while (waitreq !== 1'b0 && n < 50);
		d = rdat;
		if (n == 50) begin n_mismatch++; complete_run(); end
		wr <= 1'b0;
		rd <= 1'b0;
	endtask
	// what: 0 mode equals m, 1 temp_on high, 2 refresh tick
	task automatic wait_for(input int what, input logic [2:0] m, input int lim);
		int n;
		for (n = 0; n < lim; n++)
		begin
			@(negedge clk);
			if (what == 0 ? mode === m : what == 1 ? temp_on === 1'b1 : tick === 1'b1)
				break;
		end
		if (n == lim)
		begin
			n_mismatch++;
			$display("wrong value wait %0d expected event seen none", what);
			complete_run();
		end
	endtask
	task automatic press();
		@(posedge clk) key <= 1'b1;
		repeat (6) @(posedge clk);
		key <= 1'b0;
		repeat (6) @(posedge clk);
	endtask
	localparam logic [7:0] OFS [7] = '{8'h08, 8'h75, 8'h82, 8'h86, 8'ha5, 8'ha9, 8'haa};
	// ==========================================================
	// scenarios
	initial
	begin
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		foreach (OFS[i]) begin acc(0, OFS[i], 0); chk("reset reg", 0, d); end
		acc(1, 8'h10, 8'h5a);
		acc(0, 8'h10, 0); chk("unmapped", 0, d);
		acc(1, 8'h82, 8'h01); acc(0, 8'h82, 0); chk("enable", 1, d);
		acc(1, 8'ha9, 8'hb0); acc(1, 8'haa, 8'h5c);
		@(negedge clk) chk("win", {22'h0, 2'h3, 8'h5c}, {22'h0, wsel, page});
		acc(1, 8'h08, 8'hff); acc(1, 8'h75, 8'h5f); acc(1, 8'h86, 8'h01);
		wev <= 8'hff;
		wact <= 8'hff;
		acc(1, 8'hc0, 8'h01); acc(0, 8'h64, 0); chk("in smm", 1, d[7]);
		acc(1, 8'hc0, 8'h02); acc(0, 8'h64, 0); chk("out smm", 0, d[7]);
		acc(0, 8'h61, 0); chk("portb", 0, {31'h0, d[4]});
		wait_for(2, 0, 250);
		acc(0, 8'h61, 0); chk("portb", 1, {31'h0, d[4]});
		press();
		wait_for(0, srs_pkg::PM_LOW, 250);
		press();
		wait_for(0, srs_pkg::PM_SLEEP, 400);
		wait_for(2, 0, 250);
		@(negedge clk) chk("edge ignored", 3, mode);
		wait_for(1, 0, 1000);
		chk("s2s", 32'h5, {29'h0, smi, nmi, clk_run});
		chk("mode", 3, mode);
		acc(0, 8'ha5, 0); chk("cause s2s", 8'h08, d);
		acc(1, 8'ha2, 8'h00);
		@(negedge clk) chk("smi clr", 0, smi);
		acc(0, 8'ha5, 0); chk("reread", 8'h08, d);
		acc(1, 8'ha5, 8'h00); acc(0, 8'ha5, 0); chk("cause clr", 0, d);
		wait_for(2, 0, 250);
		@(negedge clk) chk("susp", {29'h0, 3'h4}, {29'h0, mode});
		chk("susp clk", {temp_on, clk_run}, 0);
		press();
		wait_for(0, srs_pkg::PM_HIGH, 250);
		chk("resume smi", {4'h1, 1'b1}, {taken, smi});
		acc(0, 8'ha5, 0); chk("cause res", 8'h01, d);
		@(posedge clk) ret <= 1'b1;
		@(posedge clk) ret <= 1'b0;
		@(negedge clk) chk("rearm", {1'b1, 4'h2}, {in_smm, taken});
		acc(1, 8'ha2, 8'h00); acc(1, 8'ha5, 8'h00);
		press();
		wait_for(0, srs_pkg::PM_LOW, 250);
		wait_for(1, 0, 1500);
		press();
		@(negedge clk) chk("held", 32'hb, {28'h0, temp_on, mode});
		acc(1, 8'ha2, 8'h00);
		acc(1, 8'ha5, 8'h00);
		wait_for(0, srs_pkg::PM_HIGH, 250);
		chk("replay", 0, {31'h0, temp_on});
		complete_run();
	end
endmodule // srs_sequencer_tb_top
